// ---- verilog/ccc_pkg.sv ----
// constants, types and helpers of the card mode contactless codec
package ccc_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int PER_W         = 8;

  // carrier cycles per bit for each rate code
  localparam logic [7:0] CYC_106 = 8'h80;
  localparam logic [7:0] CYC_212 = 8'h40;
  localparam logic [7:0] CYC_424 = 8'h20;
  localparam logic [7:0] CYC_SER = 8'h04;

  // subcarrier fc/16: this carrier count bit toggles every 8 cycles
  localparam int SUBC_BIT = 3;

  localparam int RST_HOLD_NS  = 100;
  localparam int RST_HOLD_CYC =
    (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [1:0] RATE_106 = 2'h0;
  localparam logic [1:0] RATE_212 = 2'h1;
  localparam logic [1:0] RATE_424 = 2'h2;
  localparam logic [1:0] RATE_SER = 2'h3;

  localparam logic [3:0] NB_A = 4'h9;
  localparam logic [3:0] NB_M = 4'h8;

  typedef enum logic {PROTO_A = 1'b0, PROTO_M = 1'b1} ccc_proto_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SOF  = 2'b01,
    TX_DATA = 2'b10,
    TX_EOF  = 2'b11
  } ccc_tx_state_t;

  typedef enum logic {RX_IDLE = 1'b0, RX_BUSY = 1'b1} ccc_rx_state_t;

  // manchester card scheme has no 106 rate; serial rate needs the modem
  function automatic logic [1:0] eff_rate(input ccc_proto_t p,
                                          input logic [1:0] r,
                                          input logic       ext);
    logic [1:0] q;
    q = r;
    if (r == RATE_SER && !ext)
      q = RATE_424;
    if (p == PROTO_M && q == RATE_106)
      q = RATE_212;
    return q;
  endfunction

  function automatic logic [7:0] period_of(input logic [1:0] r);
    logic [7:0] q;
    unique case (r)
      RATE_106: q = CYC_106;
      RATE_212: q = CYC_212;
      RATE_424: q = CYC_424;
      RATE_SER: q = CYC_SER;
    endcase
    return q;
  endfunction

  function automatic logic [7:0] bit_rev(input logic [7:0] b);
    logic [7:0] q;
    q = 8'h00;
    for (int i = 0; i < 8; i++)
      q[i] = b[7 - i];
    return q;
  endfunction

endpackage

// ---- verilog/ccc_bit_timer.sv ----
// carrier cycle counter that marks bit boundaries
`timescale 1ns/1ns
module ccc_bit_timer #(
  parameter int PW = 8
) (
  input  wire logic          clk_in,
  input  wire logic          rst_in,
  input  wire logic          tick_in,
  input  wire logic          restart_in,
  input  wire logic [PW-1:0] period_in,
  output logic      [PW-1:0] cyc_out,
  output logic               bit_end_out
);

  logic [PW-1:0] cyc_r;
  logic [PW-1:0] seen_r;

  assign cyc_out     = cyc_r;
  assign bit_end_out = tick_in && !restart_in && (cyc_r == period_in - 1'b1);

  always_ff @(posedge clk_in)
  begin
    if (rst_in || restart_in)
      cyc_r <= '0;
    else if (bit_end_out)
      cyc_r <= '0;
    else if (tick_in)
      cyc_r <= cyc_r + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // independent tick tally, only read by the check below
  always_ff @(posedge clk_in)
  begin
    if (rst_in || restart_in || bit_end_out)
      seen_r <= '0;
    else if (tick_in)
      seen_r <= seen_r + 1'b1;
  end

  a_bit_length:
    assert property (@(posedge clk_in) disable iff (rst_in)
      bit_end_out |-> (seen_r + 1'b1 == period_in) && tick_in)
    else $error("bit period differs from carrier cycle count");

endmodule

// ---- verilog/ccc_codec.sv ----
// card mode contactless codec: miller/manchester decode, reply encode
`timescale 1ns/1ns
module ccc_codec (
  input  wire logic       sys_clk_in,
  input  wire logic       resetn_in,
  input  wire logic       carrier_in,
  input  wire logic       rx_env_in,
  input  wire logic       serial_link_in,
  input  wire logic       reset_powerdown_n_in,
  input  wire logic       proto_sel_in,
  input  wire logic [1:0] rate_sel_in,
  input  wire logic       ext_modem_in,
  input  wire logic [7:0] tx_byte_in,
  input  wire logic       tx_valid_in,
  input  wire logic       tx_last_in,
  output logic            tx_ready_out,
  output logic            tx_busy_out,
  output logic [7:0]      rx_byte_out,
  output logic [3:0]      rx_nbits_out,
  output logic            rx_byte_valid_out,
  output logic            rx_err_out,
  output logic            rx_sof_out,
  output logic            rx_eof_out,
  output logic            load_modulation_out,
  output logic            serial_link_out,
  output logic            reset_indicator_n_out,
  output logic            osc_enable_out,
  output logic            bias_enable_out,
  output logic            pad_isolate_out
);

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] car_s_r, env_s_r, ser_s_r, rpd_s_r;
  logic       car_d_r, src_d_r;
  logic       core_rst_r;
  logic [7:0] hold_cnt_r;
  logic       rst_w;

  always_ff @(posedge sys_clk_in)
  begin
    if (!resetn_in)
    begin
      car_s_r <= 2'h0;
      env_s_r <= 2'h3;
      ser_s_r <= 2'h3;
      rpd_s_r <= 2'h0;
    end
    else
    begin
      car_s_r <= {car_s_r[0], carrier_in};
      env_s_r <= {env_s_r[0], rx_env_in};
      ser_s_r <= {ser_s_r[0], serial_link_in};
      rpd_s_r <= {rpd_s_r[0], reset_powerdown_n_in};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-down and internal reset; level-held so a missed edge cannot
  // leave the core running while the pin is low
  always_ff @(posedge sys_clk_in)
  begin
    if (!resetn_in)
    begin
      hold_cnt_r            <= 8'(ccc_pkg::RST_HOLD_CYC);
      core_rst_r            <= 1'b1;
      reset_indicator_n_out <= 1'b0;
      osc_enable_out        <= 1'b0;
      bias_enable_out       <= 1'b0;
      pad_isolate_out       <= 1'b1;
    end
    else
    begin
      if (!rpd_s_r[1])
        hold_cnt_r <= 8'(ccc_pkg::RST_HOLD_CYC);
      else if (hold_cnt_r != 8'h00)
        hold_cnt_r <= hold_cnt_r - 8'h01;
      core_rst_r            <= !rpd_s_r[1] || (hold_cnt_r != 8'h00);
      reset_indicator_n_out <= !core_rst_r;
      osc_enable_out        <= rpd_s_r[1];
      bias_enable_out       <= rpd_s_r[1];
      pad_isolate_out       <= !rpd_s_r[1];
    end
  end

  assign rst_w = !resetn_in || core_rst_r;

  // isolated pads look like an idle, unmodulated field
  logic env_g, ser_g, src_w, tick_w, fall_w, edge_w;
  assign env_g  = env_s_r[1] | pad_isolate_out;
  assign ser_g  = ser_s_r[1] | pad_isolate_out;
  assign src_w  = ext_modem_in ? ser_g : env_g;
  assign tick_w = car_s_r[1] && !car_d_r;
  assign fall_w = src_d_r && !src_w;
  assign edge_w = src_d_r != src_w;

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_w)
    begin
      car_d_r <= 1'b0;
      src_d_r <= 1'b1;
    end
    else
    begin
      car_d_r <= car_s_r[1];
      src_d_r <= src_w;
    end
  end

  ccc_pkg::ccc_proto_t cfg_proto_w;
  logic [1:0]          cfg_rate_w;
  assign cfg_proto_w = ccc_pkg::ccc_proto_t'(proto_sel_in);
  assign cfg_rate_w  = ccc_pkg::eff_rate(cfg_proto_w, rate_sel_in,
                                         ext_modem_in);

  ////////////////////////////////////////////////////////////////////////////
  // receive decoder
  ccc_pkg::ccc_rx_state_t rx_st_r;
  ccc_pkg::ccc_proto_t    rx_proto_r;
  logic [1:0]             rx_rate_r;
  logic [7:0]             rx_per_w, rx_cyc_w, rx_q_w;
  logic                   rx_end_w, rx_a_w;
  logic                   seen_x_r, seen_z_r, prev_x_r, sof_slot_r;
  logic                   s1_r, s2_r;
  logic                   sof_ev, eof_ev, bit_ev, bit_val;

  assign rx_per_w = ccc_pkg::period_of(rx_rate_r);
  assign rx_q_w   = rx_per_w >> 2;
  assign rx_a_w   = rx_proto_r == ccc_pkg::PROTO_A;

  ccc_bit_timer #(.PW(ccc_pkg::PER_W)) u_rx_timer (
    .clk_in      (sys_clk_in),
    .rst_in      (rst_w),
    .tick_in     (tick_w),
    .restart_in  (rx_st_r == ccc_pkg::RX_IDLE),
    .period_in   (rx_per_w),
    .cyc_out     (rx_cyc_w),
    .bit_end_out (rx_end_w)
  );

  always_comb
  begin
    sof_ev = (rx_st_r == ccc_pkg::RX_IDLE) &&
             (fall_w || (cfg_proto_w == ccc_pkg::PROTO_M && edge_w));
    // type A: no pause after a zero ends the frame; manchester: no swing
    if (rx_a_w)
      eof_ev = !seen_x_r && !seen_z_r && !prev_x_r;
    else
      eof_ev = s1_r == s2_r;
    eof_ev  = eof_ev && rx_end_w && (rx_st_r == ccc_pkg::RX_BUSY);
    bit_ev  = rx_end_w && (rx_st_r == ccc_pkg::RX_BUSY) && !eof_ev &&
              !(rx_a_w && sof_slot_r);
    bit_val = rx_a_w ? seen_x_r : s1_r;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_w)
    begin
      rx_st_r    <= ccc_pkg::RX_IDLE;
      rx_proto_r <= ccc_pkg::PROTO_A;
      rx_rate_r  <= ccc_pkg::RATE_106;
      seen_x_r   <= 1'b0;
      seen_z_r   <= 1'b0;
      prev_x_r   <= 1'b0;
      sof_slot_r <= 1'b0;
      s1_r       <= 1'b0;
      s2_r       <= 1'b0;
    end
    else if (rx_st_r == ccc_pkg::RX_IDLE)
    begin
      if (sof_ev)
      begin
        rx_st_r    <= ccc_pkg::RX_BUSY;
        rx_proto_r <= cfg_proto_w;
        rx_rate_r  <= cfg_rate_w;
        sof_slot_r <= cfg_proto_w == ccc_pkg::PROTO_A;
        prev_x_r   <= 1'b0;
        seen_x_r   <= 1'b0;
        // start pause is a Z, so the start slot never reads as an end
        seen_z_r   <= cfg_proto_w == ccc_pkg::PROTO_A;
      end
    end
    else
    begin
      if (rx_end_w)
      begin
        seen_x_r   <= 1'b0;
        seen_z_r   <= 1'b0;
        sof_slot_r <= 1'b0;
        prev_x_r   <= seen_x_r;
        if (eof_ev)
          rx_st_r <= ccc_pkg::RX_IDLE;
      end
      // a pause in the boundary cycle still counts: set after clear
      if (rx_a_w && fall_w)
      begin
        // a pause on the boundary tick opens the next slot at offset 0
        if (rx_end_w || rx_cyc_w < rx_q_w)
          seen_z_r <= 1'b1;
        else
          seen_x_r <= 1'b1;
      end
      // the tick seen at count n is carrier cycle n+1 of the slot; one
      // later would hit the mid-bit swing at the shortest period
      if (!rx_a_w && tick_w && rx_cyc_w == rx_q_w - 8'h01)
        s1_r <= src_w;
      if (!rx_a_w && tick_w &&
          rx_cyc_w == rx_q_w - 8'h01 + (rx_per_w >> 1))
        s2_r <= src_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte assembly: type A lsb first with odd parity, manchester msb first
  logic [8:0] rx_sh_r;
  logic [3:0] rx_cnt_r;
  logic [3:0] rx_nb_w;
  assign rx_nb_w = rx_a_w ? ccc_pkg::NB_A : ccc_pkg::NB_M;

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_w)
    begin
      rx_sh_r           <= 9'h000;
      rx_cnt_r          <= 4'h0;
      rx_byte_out       <= 8'h00;
      rx_nbits_out      <= 4'h0;
      rx_byte_valid_out <= 1'b0;
      rx_err_out        <= 1'b0;
      rx_sof_out        <= 1'b0;
      rx_eof_out        <= 1'b0;
    end
    else
    begin
      rx_byte_valid_out <= 1'b0;
      rx_err_out        <= 1'b0;
      rx_eof_out        <= 1'b0;
      rx_sof_out        <= sof_ev;
      if (sof_ev)
        rx_cnt_r <= 4'h0;
      if (bit_ev)
      begin
        rx_sh_r <= rx_a_w ? {bit_val, rx_sh_r[8:1]} : {rx_sh_r[7:0], bit_val};
        if (rx_cnt_r == rx_nb_w - 4'h1)
        begin
          rx_cnt_r          <= 4'h0;
          rx_byte_valid_out <= 1'b1;
          rx_nbits_out      <= ccc_pkg::NB_M;
          rx_byte_out       <= rx_a_w ? rx_sh_r[8:1] : {rx_sh_r[6:0], bit_val};
          rx_err_out        <= rx_a_w && !(^{rx_sh_r[8:1], bit_val});
        end
        else
          rx_cnt_r <= rx_cnt_r + 4'h1;
      end
      if (eof_ev)
      begin
        rx_eof_out <= 1'b1;
        rx_cnt_r   <= 4'h0;
        // short frames (e.g. 7-bit commands) are handed on low-aligned
        if (rx_cnt_r != 4'h0)
        begin
          rx_byte_valid_out <= 1'b1;
          rx_nbits_out      <= rx_cnt_r;
          rx_byte_out       <= rx_a_w ? rx_sh_r[8:1] >> (4'h8 - rx_cnt_r)
                                      : rx_sh_r[7:0];
          rx_err_out        <= !rx_a_w;
        end
      end
    end
  end

  a_miller_one:
    assert property (bit_ev && rx_a_w && seen_x_r |=> rx_sh_r[8])
    else $error("mid-bit pause not decoded as one");

  a_parity_check:
    assert property (bit_ev && rx_a_w && rx_cnt_r == 4'h8 &&
                     !(^{rx_sh_r[8:1], bit_val}) |=>
                     rx_err_out && rx_byte_valid_out)
    else $error("parity failure not flagged");

  ////////////////////////////////////////////////////////////////////////////
  // transmit encoder with a one byte holding stage
  ccc_pkg::ccc_tx_state_t tx_st_r;
  ccc_pkg::ccc_proto_t    tx_proto_r;
  logic [1:0]             tx_rate_r;
  logic [7:0]             tx_per_w, tx_cyc_w, hold_b_r;
  logic [8:0]             tx_sh_r;
  logic [3:0]             tx_left_r;
  logic                   tx_end_w, tx_last_r, hold_v_r, hold_last_r;
  logic                   take_w, load_w, tx_a_w, tx_bit_w;
  logic                   tx_half_w, subc_w, mod_nxt;

  assign tx_per_w  = ccc_pkg::period_of(tx_rate_r);
  assign tx_a_w    = tx_proto_r == ccc_pkg::PROTO_A;
  assign take_w    = tx_valid_in && tx_ready_out;
  assign tx_bit_w  = (tx_st_r == ccc_pkg::TX_SOF) ? 1'b1 : tx_sh_r[0];
  assign tx_half_w = tx_cyc_w >= (tx_per_w >> 1);
  assign subc_w    = tx_cyc_w[ccc_pkg::SUBC_BIT];
  assign load_w    = hold_v_r &&
    ((tx_st_r == ccc_pkg::TX_IDLE && cfg_proto_w == ccc_pkg::PROTO_M) ||
     (tx_st_r == ccc_pkg::TX_SOF && tx_end_w) ||
     (tx_st_r == ccc_pkg::TX_DATA && tx_end_w && tx_left_r == 4'h0 &&
      !tx_last_r));

  ccc_bit_timer #(.PW(ccc_pkg::PER_W)) u_tx_timer (
    .clk_in      (sys_clk_in),
    .rst_in      (rst_w),
    .tick_in     (tick_w),
    .restart_in  (tx_st_r == ccc_pkg::TX_IDLE),
    .period_in   (tx_per_w),
    .cyc_out     (tx_cyc_w),
    .bit_end_out (tx_end_w)
  );

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_w)
    begin
      hold_v_r     <= 1'b0;
      hold_b_r     <= 8'h00;
      hold_last_r  <= 1'b0;
      tx_ready_out <= 1'b0;
    end
    else
    begin
      hold_v_r     <= take_w || (hold_v_r && !load_w);
      tx_ready_out <= !(take_w || (hold_v_r && !load_w));
      if (take_w)
      begin
        hold_b_r    <= tx_byte_in;
        hold_last_r <= tx_last_in;
      end
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_w)
    begin
      tx_st_r     <= ccc_pkg::TX_IDLE;
      tx_proto_r  <= ccc_pkg::PROTO_A;
      tx_rate_r   <= ccc_pkg::RATE_106;
      tx_sh_r     <= 9'h000;
      tx_left_r   <= 4'h0;
      tx_last_r   <= 1'b0;
      tx_busy_out <= 1'b0;
    end
    else
    begin
      tx_busy_out <= tx_st_r != ccc_pkg::TX_IDLE;
      unique case (tx_st_r)
        ccc_pkg::TX_IDLE:
          if (hold_v_r)
          begin
            tx_proto_r <= cfg_proto_w;
            tx_rate_r  <= cfg_rate_w;
            tx_st_r    <= (cfg_proto_w == ccc_pkg::PROTO_A) ?
                          ccc_pkg::TX_SOF : ccc_pkg::TX_DATA;
          end
        ccc_pkg::TX_SOF:
          if (tx_end_w)
            tx_st_r <= ccc_pkg::TX_DATA;
        ccc_pkg::TX_DATA:
          if (tx_end_w)
          begin
            tx_sh_r   <= tx_sh_r >> 1;
            tx_left_r <= tx_left_r - 4'h1;
            // last byte or underrun closes the frame
            if (tx_left_r == 4'h0 && !load_w)
              tx_st_r <= tx_a_w ? ccc_pkg::TX_EOF : ccc_pkg::TX_IDLE;
          end
        ccc_pkg::TX_EOF:
          if (tx_end_w)
            tx_st_r <= ccc_pkg::TX_IDLE;
      endcase
      if (load_w)
      begin
        tx_last_r <= hold_last_r;
        if (tx_st_r == ccc_pkg::TX_IDLE ? cfg_proto_w == ccc_pkg::PROTO_A
                                        : tx_a_w)
        begin
          tx_sh_r   <= {~^hold_b_r, hold_b_r};
          tx_left_r <= ccc_pkg::NB_A - 4'h1;
        end
        else
        begin
          tx_sh_r   <= {1'b0, ccc_pkg::bit_rev(hold_b_r)};
          tx_left_r <= ccc_pkg::NB_M - 4'h1;
        end
      end
    end
  end

  always_comb
  begin
    mod_nxt = 1'b0;
    if (tx_st_r == ccc_pkg::TX_SOF || tx_st_r == ccc_pkg::TX_DATA)
    begin
      if (tx_a_w && tx_rate_r == ccc_pkg::RATE_106)
        mod_nxt = (tx_bit_w ^ tx_half_w) & subc_w;
      else if (tx_a_w && tx_rate_r != ccc_pkg::RATE_SER)
        mod_nxt = subc_w ^ ~tx_bit_w;
      else
        mod_nxt = tx_bit_w ^ tx_half_w;
    end
  end

  // one coded stream, steered to the external modem or the modulation pin
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_w)
    begin
      load_modulation_out <= 1'b0;
      serial_link_out     <= 1'b0;
    end
    else
    begin
      load_modulation_out <= !ext_modem_in && mod_nxt;
      serial_link_out     <= ext_modem_in && mod_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_rst_ind_low:
    assert property (core_rst_r |=> !reset_indicator_n_out)
    else $error("reset indicator high during internal reset");

  a_pd_shutdown:
    assert property (!rpd_s_r[1] |=>
                     core_rst_r && !osc_enable_out && pad_isolate_out)
    else $error("power-down did not stop and isolate the core");

  a_pd_release:
    assert property ($rose(rpd_s_r[1]) |=> core_rst_r[*8])
    else $error("internal reset released too early");

  a_rate_frozen:
    assert property (tx_st_r != ccc_pkg::TX_IDLE &&
                     $past(tx_st_r) != ccc_pkg::TX_IDLE |->
                     $stable(tx_rate_r) && $stable(tx_proto_r))
    else $error("rate changed inside a frame");

  a_bpsk_phase:
    assert property (tx_st_r == ccc_pkg::TX_DATA && tx_a_w && !rst_w &&
                     tx_rate_r != ccc_pkg::RATE_106 &&
                     tx_rate_r != ccc_pkg::RATE_SER && !ext_modem_in |=>
                     load_modulation_out == ($past(subc_w) ^ !$past(tx_bit_w)))
    else $error("bpsk subcarrier phase wrong");

  a_manch_half:
    assert property (tx_st_r == ccc_pkg::TX_DATA && !tx_a_w && !rst_w &&
                     !tx_half_w && !ext_modem_in |=>
                     load_modulation_out == $past(tx_bit_w))
    else $error("manchester first half wrong");

  a_serial_route:
    assert property (ext_modem_in && !rst_w |=>
                     !load_modulation_out && serial_link_out == $past(mod_nxt))
    else $error("serial link not carrying coded stream");

endmodule

// ---- sim/ccc_reader_model.sv ----
// reader/writer model: carrier, miller pauses, manchester levels
`timescale 1ns/1ns
module ccc_reader_model (
  output logic carrier_out,
  output logic env_out,
  output logic ser_out
);
  // field stays on between frames, so envelope idles high
  initial
  begin
    carrier_out = 1'b0;
    env_out     = 1'b1;
    ser_out     = 1'b1;
    // even half period keeps carrier edges off the bench clock's rise
    forever #36 carrier_out = ~carrier_out;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge carrier_out);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // one slot of p carrier cycles, pause starting at off (off < 0: none)
  task automatic slot(input int p, input int off);
    if (off < 0)
      cyc(p);
    else
    begin
      cyc(off);
      env_out = 1'b0;
      cyc(p / 8);
      env_out = 1'b1;
      cyc(p - off - p / 8);
    end
  endtask

  // start Z, data lsb first with odd parity, then logic 0 and Y
  task automatic send_miller(input int p, input logic [7:0] d,
                             input bit bad);
    logic [8:0] b;
    bit         prev;
    b = {(~^d) ^ bad, d};
    prev = 1'b0;
    // frames start on a carrier edge, as a real field does
    cyc(1);
    slot(p, 0);
    for (int i = 0; i < 9; i++)
    begin
      slot(p, b[i] ? p / 2 : (prev ? -1 : 0));
      prev = b[i];
    end
    slot(p, prev ? -1 : 0);
    slot(p, -1);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // manchester msb first; a slot of equal halves closes the frame
  task automatic send_manch(input int p, input logic [7:0] d,
                            input bit ser);
    cyc(1);
    for (int i = 7; i >= 0; i--)
    begin
      if (ser) ser_out = d[i]; else env_out = d[i];
      cyc(p / 2);
      if (ser) ser_out = ~d[i]; else env_out = ~d[i];
      cyc(p / 2);
    end
    cyc(p);
  endtask
endmodule

// ---- sim/testbench.sv ----
// self-checking bench of the card mode contactless codec
`timescale 1ns/1ns
module testbench;
  logic       clk, rstn, pd_n, proto, ext, txv, txl;
  logic [1:0] rate;
  logic [7:0] txb, rb;
  logic [3:0] rn;
  logic       re, got, fin;
  wire        car, env, ser, rdy, busy, bv, err, sof, eof, lm, so;
  wire        rin, osc, bias, iso;
  wire  [7:0] rxb;
  wire  [3:0] nb;
  int         bad_count, comparisons, ticks;

  ccc_reader_model rdr (.carrier_out(car), .env_out(env), .ser_out(ser));

  ccc_codec DUT (
    .sys_clk_in(clk), .resetn_in(rstn), .carrier_in(car), .rx_env_in(env),
    .serial_link_in(ser), .reset_powerdown_n_in(pd_n), .proto_sel_in(proto),
    .rate_sel_in(rate), .ext_modem_in(ext), .tx_byte_in(txb),
    .tx_valid_in(txv), .tx_last_in(txl), .tx_ready_out(rdy),
    .tx_busy_out(busy), .rx_byte_out(rxb), .rx_nbits_out(nb),
    .rx_byte_valid_out(bv), .rx_err_out(err), .rx_sof_out(sof),
    .rx_eof_out(eof), .load_modulation_out(lm), .serial_link_out(so),
    .reset_indicator_n_out(rin), .osc_enable_out(osc),
    .bias_enable_out(bias), .pad_isolate_out(iso));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // keep the first byte of each frame; an end marker may add a partial
  always @(posedge clk)
    if (sof) got <= 1'b0;
    else if (bv && !got)
    begin
      got <= 1'b1;
      rb  <= rxb;
      rn  <= nb;
      re  <= err;
    end

  // frame closed by an end marker since its start
  always @(posedge clk)
    if (sof || eof) fin <= eof;

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // whole run is about 45k cycles
  always @(posedge clk)
  begin
    ticks++;
    if (ticks == 90000)
    begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic wait_hi(input logic s, input int lim);
    for (int w = 0; w < lim && s !== 1'b1; w++)
      @(posedge clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // power-down pin low: core in reset, oscillator and sources off
  task automatic t_powerdown;
    @(posedge clk);
    #1 pd_n = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    check({osc, bias, iso, rin, rdy}, 16'h0004);
    pd_n = 1'b1;
    repeat (20) @(posedge clk);
    #1;
    check({osc, bias, iso, rin, rdy}, 16'h001b);
  endtask

  // one frame; frame length counted in carrier cycles while busy
  task automatic t_tx(input logic p, input logic [1:0] r, input logic e,
                      input int len);
    int n, on, off;
    proto = p;
    rate  = r;
    ext   = e;
    txb   = 8'h5a;
    txl   = 1'b1;
    for (int w = 0; w < 100 && rdy !== 1'b1; w++)
      @(posedge clk);
    #1 txv = 1'b1;
    @(posedge clk);
    #1 txv = 1'b0;
    for (int w = 0; w < 20 && busy !== 1'b1; w++)
      @(posedge clk);
    n = 0;
    on = 0;
    off = 0;
    while (busy === 1'b1 && n < 3000)
    begin
      @(posedge car);
      n++;
      on  += (e ? so : lm) === 1'b1;
      off += (e ? lm : so) === 1'b1;
    end
    check((n >= len - 3 && n <= len + 3) ? len : n, len);
    check(on > 0, 1'b1);
    check(off, 0);
    repeat (5) @(posedge clk);
    #1;
  endtask

  task automatic t_rx(input logic p, input logic [1:0] r, input logic e,
                      input int per, input logic [7:0] d, input bit bad);
    proto = p;
    rate  = r;
    ext   = e;
    if (p == 1'b0)
      rdr.send_miller(per, d, bad);
    else
      rdr.send_manch(per, d, e);
    repeat (50) @(posedge clk);
    #1;
    check(rb, d);
    check({rn, re, got, fin}, {4'h8, bad, 2'b11});
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    bad_count = 0;
    comparisons = 0;
    ticks = 0;
    rstn = 1'b0;
    pd_n = 1'b1;
    proto = 1'b0;
    rate = 2'h0;
    ext = 1'b0;
    txv = 1'b0;
    txl = 1'b0;
    txb = 8'h00;
    got = 1'b0;
    repeat (20) @(posedge clk);
    #1;
    check({rin, iso, rdy}, 16'h0002);
    rstn = 1'b1;
    repeat (25) @(posedge clk);
    #1;
    check({rin, osc, iso}, 16'h0006);
    t_powerdown();
    t_tx(1'b0, 2'h0, 1'b0, 11 * 128);
    t_tx(1'b0, 2'h1, 1'b0, 11 * 64);
    t_tx(1'b0, 2'h2, 1'b0, 11 * 32);
    t_tx(1'b1, 2'h0, 1'b0, 8 * 64);
    t_tx(1'b1, 2'h2, 1'b0, 8 * 32);
    t_tx(1'b1, 2'h3, 1'b1, 8 * int'(ccc_pkg::CYC_SER));
    t_tx(1'b0, 2'h3, 1'b1, 11 * int'(ccc_pkg::CYC_SER));
    t_rx(1'b0, 2'h0, 1'b0, 128, 8'ha5, 1'b0);
    t_rx(1'b0, 2'h2, 1'b0, 32, 8'h3c, 1'b1);
    t_rx(1'b1, 2'h1, 1'b0, 64, 8'h34, 1'b0);
    t_rx(1'b1, 2'h3, 1'b1, 4, 8'h14, 1'b0);
    wrap_up();
  end
endmodule
